// ### src/tms_pkg.sv
/*
 * Constants shared by the timer set: register indices, control bit
 * positions, writable-bit masks, prescaler terminal counts and reset values.
 * Assumes a 16-bit register port with a 5-bit word index.
 */
package tms_pkg;

    // ------------------------------------------------------------------
    // Channel numbering
    // ------------------------------------------------------------------
    localparam int NUM_CH      = 5;       // Standalone plus two pairs
    localparam int CH_ALONE    = 0;       // Standalone timer channel
    localparam int CH_ADC_UP   = 4;       // Upper timer of second pair

    // ------------------------------------------------------------------
    // Register indices (three words per channel, then shared words)
    // ------------------------------------------------------------------
    localparam int         ADR_W       = 5;
    localparam logic [4:0] ADR_STRIDE  = 5'h03; // Words per channel
    localparam logic [4:0] ADR_CTRL    = 5'h00; // Control word offset
    localparam logic [4:0] ADR_COUNT   = 5'h01; // Count word offset
    localparam logic [4:0] ADR_PERIOD  = 5'h02; // Period word offset
    localparam logic [4:0] ADR_FLAGS   = 5'h0f; // Event flags, write 1 clears
    localparam logic [4:0] ADR_HOLD0   = 5'h10; // Upper word hold, pair 0
    localparam logic [4:0] ADR_HOLD1   = 5'h11; // Upper word hold, pair 1

    // ------------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------------
    localparam int BIT_RUN   = 15; // run_enable_bit
    localparam int BIT_IDLE  = 13; // idle_stop_bit
    localparam int BIT_GATE  = 6;  // gate_accumulate_bit
    localparam int BIT_PS_HI = 5;  // prescale_select msb
    localparam int BIT_PS_LO = 4;  // prescale_select lsb
    localparam int BIT_JOIN  = 3;  // pair_join_bit (lower timers)
    localparam int BIT_SYNC  = 2;  // ext_clock_sync_bit (standalone)
    localparam int BIT_SRC   = 1;  // clock_source_bit

    // Writable bits per control register kind; the rest read as zero
    localparam logic [15:0] MASK_ALONE = 16'ha076;
    localparam logic [15:0] MASK_LOWER = 16'ha07a;
    localparam logic [15:0] MASK_UPPER = 16'ha072;

    // ------------------------------------------------------------------
    // Prescaler terminal counts (divide ratio minus one)
    // ------------------------------------------------------------------
    localparam logic [7:0] PS_TERM_1   = 8'h00; // 1:1
    localparam logic [7:0] PS_TERM_8   = 8'h07; // 1:8
    localparam logic [7:0] PS_TERM_64  = 8'h3f; // 1:64
    localparam logic [7:0] PS_TERM_256 = 8'hff; // 1:256

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [4:0]  RST_FLAGS  = 5'h00;

endpackage

// ### src/tms_timer_set.sv
/*
 * Timer set: one standalone 16-bit timer/counter and two pairs of 16-bit
 * timers that may be joined into 32-bit timers. Period match and gate
 * falling edge set sticky flags; the second pair also fires a converter
 * trigger. Assumes core_clk_i is the oscillator clock (the internal count
 * clock is half of it), idle and sleep come from same-clock core logic,
 * and timer pins are asynchronous.
 */
`timescale 1ns/10ps

module tms_timer_set
    import tms_pkg::*;
#(
    parameter int PRE_W = 8            // Prescaler counter width
) (
    input  wire logic              core_clk_i,  // Oscillator clock
    input  wire logic              rst_i,       // Async reset, high
    input  wire logic [ADR_W-1:0]  addr_i,      // Register word index
    input  wire logic [15:0]       wdata_i,     // Write data
    input  wire logic              wr_i,        // Write strobe
    input  wire logic              rd_i,        // Read strobe
    output logic      [15:0]       rdata_o,     // Read data, next cycle
    input  wire logic              idle_i,      // Device in Idle
    input  wire logic              sleep_i,     // Device in Sleep
    input  wire logic [NUM_CH-1:0] tmr_pin_i,   // Clock/gate pins
    output logic      [NUM_CH-1:0] flag_o,      // Sticky event flags
    output logic                   adc_trig_o   // Converter trigger pulse
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // The 1:256 ratio needs at least eight prescaler bits
    if (PRE_W < 8) begin : g_bad_pre
        $error("PRE_W must be at least 8");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0]       ctrl_q  [NUM_CH];  // Control words
    logic [15:0]       cnt_q   [NUM_CH];  // Count words
    logic [15:0]       cnt_d   [NUM_CH];  // Next count words
    logic [15:0]       per_q   [NUM_CH];  // Period words
    logic [PRE_W-1:0]  pre_q   [NUM_CH];  // Prescaler counters
    logic [PRE_W-1:0]  pre_d   [NUM_CH];  // Next prescaler counters
    logic [15:0]       hold_q  [2];       // upper_word_hold per pair
    logic [NUM_CH-1:0] pin_m_q;           // Synchroniser first stage
    logic [NUM_CH-1:0] pin_s_q;           // Synchronised pins
    logic [NUM_CH-1:0] pin_p_q;           // Previous synchronised pins
    logic [NUM_CH-1:0] rise_q;            // Registered rise, sync path
    logic              tcy_q;             // Internal clock phase
    logic [NUM_CH-1:0] flag_q;            // Sticky flags
    logic [NUM_CH-1:0] flag_d;            // Next flags
    logic              adc_q;             // Trigger pulse
    logic [15:0]       rdata_q;           // Read data register

    // ------------------------------------------------------------------
    // Decode and per-channel clocking
    // ------------------------------------------------------------------
    wire               tcy_tick = tcy_q & ~sleep_i; // Internal tick
    wire [NUM_CH-1:0]  rise     = pin_s_q & ~pin_p_q;
    wire [NUM_CH-1:0]  fall     = ~pin_s_q & pin_p_q;
    logic [NUM_CH-1:0] wr_ctrl;   // Control word write
    logic [NUM_CH-1:0] wr_cnt;    // Count word write
    logic [NUM_CH-1:0] wr_per;    // Period word write
    logic [NUM_CH-1:0] rd_cnt;    // Count word read
    logic [NUM_CH-1:0] run;       // Channel allowed to count
    logic [NUM_CH-1:0] src_ev;    // Source event before prescaler
    logic [NUM_CH-1:0] tick;      // Counting tick after prescaler
    logic [NUM_CH-1:0] gate_fall; // Gate falling edge event
    logic [NUM_CH-1:0] match;     // 16-bit period equality
    logic [1:0]        join_p;    // Pair joined into 32 bits

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [4:0] BASE = 5'(i) * ADR_STRIDE;
        wire [15:0] c       = ctrl_q[i];
        wire        ext     = c[BIT_SRC];
        // Only the standalone timer may count the raw pin edge
        wire        async_m = (i == CH_ALONE) && ext && !c[BIT_SYNC];
        wire        ext_ev  = async_m ? rise[i]
                                      : rise_q[i] & ~sleep_i;
        wire        int_ev  = tcy_tick &
                              (~c[BIT_GATE] | pin_s_q[i]);
        wire [1:0]  ps      = c[BIT_PS_HI:BIT_PS_LO];
        wire [PRE_W-1:0] term = (ps == 2'b00) ? PRE_W'(PS_TERM_1)
                              : (ps == 2'b01) ? PRE_W'(PS_TERM_8)
                              : (ps == 2'b10) ? PRE_W'(PS_TERM_64)
                              : PRE_W'(PS_TERM_256);

        assign wr_ctrl[i]   = wr_i & (addr_i == BASE + ADR_CTRL);
        assign wr_cnt[i]    = wr_i & (addr_i == BASE + ADR_COUNT);
        assign wr_per[i]    = wr_i & (addr_i == BASE + ADR_PERIOD);
        assign rd_cnt[i]    = rd_i & (addr_i == BASE + ADR_COUNT);
        // Run bit gates counting; idle-stop halts in Idle
        assign run[i]       = c[BIT_RUN] &
                              ~(idle_i & c[BIT_IDLE]);
        assign src_ev[i]    = ext ? ext_ev : int_ev;
        assign tick[i]      = run[i] & src_ev[i] & (pre_q[i] == term);
        assign gate_fall[i] = c[BIT_RUN] & ~ext & c[BIT_GATE] & fall[i];
        assign match[i]     = cnt_q[i] == per_q[i];

        // Prescaler restarts on any control write or while stopped
        always_comb begin
            if (!run[i] || wr_ctrl[i]) begin
                pre_d[i] = '0;
            end else if (src_ev[i]) begin
                pre_d[i] = (pre_q[i] == term) ? '0 : pre_q[i] + 1'b1;
            end else begin
                pre_d[i] = pre_q[i];
            end
        end
    end

    assign join_p[0] = ctrl_q[1][BIT_JOIN];
    assign join_p[1] = ctrl_q[3][BIT_JOIN];

    // ------------------------------------------------------------------
    // Count and flag next state
    // ------------------------------------------------------------------
    // Flags set on the tick that wraps the count; set beats a clear.
    logic [NUM_CH-1:0] set_v;    // Flag set events
    logic              adc_d;    // Trigger next value
    always_comb begin
        int lo;
        int up;
        logic [31:0] wide;
        lo    = 0;
        up    = 0;
        wide  = 32'h0;
        set_v = '0;
        adc_d = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            cnt_d[i] = cnt_q[i];
        end
        // Standalone timer
        if (tick[CH_ALONE]) begin
            cnt_d[CH_ALONE] = match[CH_ALONE] ? 16'h0000
                                              : cnt_q[CH_ALONE] + 16'h0001;
        end
        set_v[CH_ALONE] = (tick[CH_ALONE] & match[CH_ALONE]) |
                          gate_fall[CH_ALONE];
        for (int p = 0; p < 2; p++) begin
            lo = 1 + 2 * p;
            up = 2 + 2 * p;
            if (join_p[p]) begin
                // Upper controls and pin ignored; lower drives both words
                wide = {cnt_q[up], cnt_q[lo]} + 32'h0000_0001;
                if (tick[lo]) begin
                    if (match[lo] && match[up]) begin
                        cnt_d[lo] = 16'h0000;
                        cnt_d[up] = 16'h0000;
                        set_v[up] = 1'b1;
                    end else begin
                        cnt_d[lo] = wide[15:0];
                        cnt_d[up] = wide[31:16];
                    end
                end
                set_v[up] = set_v[up] | gate_fall[lo];
            end else begin
                // Two separate 16-bit timers
                for (int k = lo; k <= up; k++) begin
                    if (tick[k]) begin
                        cnt_d[k] = match[k] ? 16'h0000
                                            : cnt_q[k] + 16'h0001;
                    end
                    set_v[k] = (tick[k] & match[k]) | gate_fall[k];
                end
            end
        end
        // Trigger: second pair only, upper timer or joined match
        adc_d = join_p[1] ? (tick[3] & match[3] & match[4])
                          : (tick[CH_ADC_UP] & match[CH_ADC_UP]);
        // Software write of a count word wins over counting
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr_cnt[i]) begin
                cnt_d[i] = wdata_i;
            end
        end
    end

    // Write-one-to-clear, set wins
    wire clr_flags = wr_i & (addr_i == ADR_FLAGS);
    assign flag_d = (flag_q & ~(clr_flags ? wdata_i[NUM_CH-1:0] : '0))
                  | set_v;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    logic [15:0] rd_mux;  // Selected word
    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < NUM_CH; i++) begin
            if (addr_i == 5'(i) * ADR_STRIDE + ADR_CTRL) begin
                rd_mux = ctrl_q[i];
            end
            if (addr_i == 5'(i) * ADR_STRIDE + ADR_COUNT) begin
                rd_mux = cnt_q[i];
            end
            if (addr_i == 5'(i) * ADR_STRIDE + ADR_PERIOD) begin
                rd_mux = per_q[i];
            end
        end
        if (addr_i == ADR_FLAGS) begin
            rd_mux = {11'h000, flag_q};
        end
        if (addr_i == ADR_HOLD0) begin
            rd_mux = hold_q[0];
        end
        if (addr_i == ADR_HOLD1) begin
            rd_mux = hold_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and internal clock phase
    // ------------------------------------------------------------------
    // Extra rise stage aligns synchronised clocks; async path skips it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
            pin_p_q <= '0;
            rise_q  <= '0;
            tcy_q   <= 1'b0;
        end else begin
            pin_m_q <= tmr_pin_i;
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
            rise_q  <= rise;
            tcy_q   <= ~tcy_q & ~sleep_i;  // Stops in Sleep
        end
    end

    // ------------------------------------------------------------------
    // Control, period, count and prescaler registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_q[i] <= RST_CTRL;
                per_q[i]  <= RST_PERIOD;
                cnt_q[i]  <= RST_COUNT;
                pre_q[i]  <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_ctrl[i]) begin
                    ctrl_q[i] <= wdata_i & ((i == CH_ALONE) ? MASK_ALONE
                                          : (i % 2 == 1) ? MASK_LOWER
                                          : MASK_UPPER);
                end
                if (wr_per[i]) begin
                    per_q[i] <= wdata_i;
                end
                cnt_q[i] <= cnt_d[i];
                pre_q[i] <= pre_d[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Hold words, flags, trigger and read data
    // ------------------------------------------------------------------
    // Lower-word read latches the upper word for a coherent 32-bit read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_q[0] <= RST_COUNT;
            hold_q[1] <= RST_COUNT;
            flag_q    <= RST_FLAGS;
            adc_q     <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            if (rd_cnt[1] && join_p[0]) begin
                hold_q[0] <= cnt_q[2];
            end
            if (rd_cnt[3] && join_p[1]) begin
                hold_q[1] <= cnt_q[4];
            end
            flag_q  <= flag_d;
            adc_q   <= adc_d;
            rdata_q <= rd_i ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o    = rdata_q;
    assign flag_o     = flag_q;
    assign adc_trig_o = adc_q;

endmodule

// ### testbench/tms_timer_set_asserts.sv
/* Checker for the timer set: register readback, flag and trigger timing.
   Assumes it is bound to tms_timer_set and sees only its ports. */
`timescale 1ns/10ps
module tms_timer_set_asserts
    import tms_pkg::*;
(
    input wire logic              core_clk_i, // Oscillator clock
    input wire logic              rst_i,      // Async reset, high
    input wire logic [ADR_W-1:0]  addr_i,     // Register word index
    input wire logic [15:0]       wdata_i,    // Write data
    input wire logic              wr_i,       // Write strobe
    input wire logic              rd_i,       // Read strobe
    input wire logic [15:0]       rdata_o,    // Read data
    input wire logic [NUM_CH-1:0] flag_o,     // Sticky flags
    input wire logic              adc_trig_o  // Converter trigger
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Helper: how long the standalone timer has been stopped
    // ------------------------------------------------------------------
    logic       run_q, run_d;   // Mirror of the standalone run bit
    logic [3:0] stop_q, stop_d; // Stopped cycles, saturates at 8
    wire        ctl0_wr = wr_i && addr_i == ADR_CTRL; // Standalone ctrl
    wire        flg_clr = wr_i && addr_i == ADR_FLAGS; // Flag clear write
    assign run_d  = ctl0_wr ? wdata_i[BIT_RUN] : run_q;
    assign stop_d = run_q ? 4'h0 : (stop_q == 4'h8 ? 4'h8 : stop_q + 4'h1);
    // Eight cycles leave room for the sync and prescaler pipeline
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q  <= 1'b0;
            stop_q <= 4'h0;
        end else begin
            run_q  <= run_d;
            stop_q <= stop_d;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_wr(a); wr_i && addr_i == a; endsequence
    sequence s_rd(a); rd_i && addr_i == a; endsequence
    // Write then read back at once gives the writable bits only
    property p_rb(a, m);
        s_wr(a) ##1 s_rd(a) |=> rdata_o == ($past(wdata_i, 2) & m);
    endproperty
    AST_CTRL_ALONE: assert property (p_rb(ADR_CTRL, MASK_ALONE))
        else $error("standalone control readback wrong");
    AST_CTRL_LOWER: assert property (p_rb(5'h03, MASK_LOWER))
        else $error("lower control readback wrong");
    AST_CTRL_UPPER: assert property (p_rb(5'h06, MASK_UPPER))
        else $error("upper control readback wrong");
    AST_PERIOD_RB: assert property (p_rb(5'h0b, 16'hffff))
        else $error("period word readback wrong");
    AST_FLAG_STICKY: assert property (!flg_clr |=>
        (flag_o & $past(flag_o)) == $past(flag_o))
        else $error("flag dropped without a clear");
    AST_TRIG_PULSE: assert property (adc_trig_o |=> !adc_trig_o)
        else $error("trigger longer than one cycle");
    AST_TRIG_FLAG: assert property (adc_trig_o |-> ##[0:2] flag_o[4])
        else $error("trigger without second pair flag");
    AST_STOP_NO_FLAG: assert property (stop_q == 4'h8 |->
        !$rose(flag_o[0]))
        else $error("stopped timer raised its flag");
endmodule

bind tms_timer_set tms_timer_set_asserts tms_timer_set_asserts_inst (
    .core_clk_i (core_clk_i), .rst_i (rst_i), .addr_i (addr_i),
    .wdata_i (wdata_i), .wr_i (wr_i), .rd_i (rd_i), .rdata_o (rdata_o),
    .flag_o (flag_o), .adc_trig_o (adc_trig_o));

// ### testbench/tms_pin_model.sv
/* Far-side pin model: drives the five timer pins as levels or as square
   waves. Assumes the bench turns toggling on for whole bursts. */
`timescale 1ns/10ps
module tms_pin_model (
    input  wire logic       core_clk_i, // Reference clock
    input  wire logic [4:0] lvl_i,      // Level when not toggling
    input  wire logic [4:0] tog_i,      // Toggle enable per pin
    input  wire logic [7:0] half_i,     // Half period in clocks
    output logic      [4:0] pin_o       // Pins to the timer set
);
    logic [7:0] cnt_q  = 8'h00; // Clocks since last toggle
    logic [4:0] wave_q = 5'h00; // Square wave, restarts low
    // Restarting low means a burst of 2*half*n clocks gives n rises
    always @(posedge core_clk_i) begin
        if (tog_i == 5'h00) begin
            cnt_q  <= 8'h00;
            wave_q <= 5'h00;
        end else if (cnt_q == half_i - 8'h01) begin
            cnt_q  <= 8'h00;
            wave_q <= ~wave_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Gate level straight from the bench when not clocking
    assign pin_o = (tog_i & wave_q) | (~tog_i & lvl_i);
endmodule

// ### testbench/testbench.sv
/* Self-checking bench for the timer set: registers, prescaled matches,
   idle stop, external counting, gate fall and joined pairs.
   Assumes the package, design and pin model are compiled first. */
`timescale 1ns/10ps
module testbench;
    import tms_pkg::*;
    logic             core_clk = 1'b0;  // 20 MHz clock
    logic             rst      = 1'b1;  // Reset, high
    logic [ADR_W-1:0] addr     = 5'h00; // Word index
    logic [15:0]      wdata    = 16'h0000;
    logic             wr       = 1'b0;
    logic             rd       = 1'b0;
    logic             idle     = 1'b0;
    logic             sleep    = 1'b0;
    logic [4:0]       lvl      = 5'h00; // Pin levels
    logic [4:0]       tog      = 5'h00; // Pin toggling
    logic [7:0]       half     = 8'h02; // Pin half period
    logic [4:0]       pins, flags;
    logic [15:0]      rdata, d, e;
    logic             trig;
    int               n_mismatch = 0, n_tests = 0;
    int               n_trig = 0, cyc = 0, t0, t1;
    int               ratio[4] = '{1, 8, 64, 256};
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (trig === 1'b1) n_trig <= n_trig + 1;
    end
    tms_timer_set tms_timer_set_inst (
        .core_clk_i (core_clk), .rst_i (rst), .addr_i (addr),
        .wdata_i (wdata), .wr_i (wr), .rd_i (rd), .rdata_o (rdata),
        .idle_i (idle), .sleep_i (sleep), .tmr_pin_i (pins),
        .flag_o (flags), .adc_trig_o (trig));
    tms_pin_model tms_pin_model_inst (
        .core_clk_i (core_clk), .lvl_i (lvl), .tog_i (tog),
        .half_i (half), .pin_o (pins));
    // ------------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic chkf(input logic [4:0] got, input logic [4:0] exp);
        chk16({11'h000, got}, {11'h000, exp});
    endtask
    // Strobe stays up until the next task, so no double assignment
    task automatic wrr(input logic [4:0] a, input logic [15:0] v);
        wr    <= 1'b1;
        rd    <= 1'b0;
        addr  <= a;
        wdata <= v;
        @(posedge core_clk);
    endtask
    task automatic rdr(input logic [4:0] a, output logic [15:0] v);
        rd   <= 1'b1;
        wr   <= 1'b0;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        v = rdata;
        @(posedge core_clk);
    endtask
    task automatic nop(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    // Bounded wait for one flag; t1 notes the cycle it was seen
    task automatic wait_flag(input int b, input int lim);
        int k;
        k = 0;
        nop(1);
        while (k < lim && flags[b] !== 1'b1) begin
            @(negedge core_clk);
            k++;
        end
        t1 = cyc;
        // Judge by the flag itself, so a hit on the last look still counts
        if (flags[b] !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        @(posedge core_clk);
    endtask
    function automatic logic [15:0] mask_of(input int c);
        return c == 0 ? MASK_ALONE : (c % 2 ? MASK_LOWER : MASK_UPPER);
    endfunction
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(91169));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int c = 0; c < NUM_CH; c++) begin // random control readback
            d = 16'($urandom) & 16'h7fff;
            wrr(5'(3 * c), d);
            rdr(5'(3 * c), e);
            chk16(e, d & mask_of(c));
        end
        rst <= 1'b1; // second reset in mid-run
        nop(3);
        rst <= 1'b0;
        for (int k = 0; k < 18; k++) begin // 0x0f flags, 0x10/0x11 holds
            rdr(5'(k), d);
            chk16(d, (k < 15 && k % 3 == 2) ? 16'hffff : 16'h0000);
        end
        rdr(5'h1f, d);
        chk16(d, 16'h0000);
        wrr(ADR_PERIOD, 16'h0002); // every prescale, exact match interval
        for (int p = 0; p < 4; p++) begin
            wrr(ADR_CTRL, 16'h8000 | 16'(p << BIT_PS_LO));
            // Flag left over from the last ratio would end the wait at once
            wrr(ADR_FLAGS, 16'h001f);
            wait_flag(0, 2000);
            t0 = t1;
            wrr(ADR_FLAGS, 16'h001f);
            wait_flag(0, 2000);
            chk16(16'(t1 - t0), 16'(6 * ratio[p]));
        end
        wrr(ADR_PERIOD, 16'hffff); // idle with and without idle stop
        for (int m = 0; m < 2; m++) begin
            wrr(ADR_CTRL, m ? 16'h8000 : 16'ha000);
            idle <= 1'b1;
            rdr(ADR_COUNT, d);
            nop(20);
            rdr(ADR_COUNT, e);
            chk16(e - d, m ? 16'h000b : 16'h0000);
            idle <= 1'b0;
        end
        for (int m = 0; m < 2; m++) begin // async in sleep, then synced
            // Source first: an internal tick cannot land after the clear
            wrr(ADR_CTRL, m ? 16'h8046 : 16'h8042);
            wrr(ADR_COUNT, 16'h0000);
            sleep <= (m == 0);
            half  <= m ? 8'h07 : 8'h02;
            tog   <= 5'h01;
            nop(m ? 70 : 20);
            tog <= 5'h00;
            nop(8);
            rdr(ADR_COUNT, d);
            chk16(d, 16'h0005);
            sleep <= 1'b0;
        end
        wrr(ADR_FLAGS, 16'h001f); // gated, then gate falls
        wrr(ADR_CTRL, 16'h8040);
        lvl <= 5'h01;
        nop(40);
        lvl <= 5'h00;
        wait_flag(0, 10);
        chkf(flags, 5'h01);
        // Five earlier counts plus 20 ticks over 40 synced high cycles
        rdr(ADR_COUNT, d);
        chk16(d, 16'h0019);
        wrr(ADR_CTRL, 16'h0000);
        wrr(5'h09, 16'h0008); // joined pair, set up in order
        wrr(5'h0c, 16'ha032);
        wrr(5'h0b, 16'h0002);
        rdr(5'h0b, d);
        chk16(d, 16'h0002);
        wrr(5'h0e, 16'h0001);
        wrr(5'h0a, 16'hfffc);
        wrr(5'h0d, 16'h0000);
        wrr(ADR_FLAGS, 16'h001f);
        t0 = n_trig;
        wrr(5'h09, 16'h8008);
        wait_flag(4, 40);
        chkf(flags, 5'h10);
        nop(3);
        chk16(16'(n_trig - t0), 16'h0001);
        wrr(5'h09, 16'h0000); // separate timers again
        for (int c = 2; c <= 4; c += 2) begin
            wrr(5'(3 * c + 1), 16'h0000);
            wrr(5'(3 * c + 2), 16'h0003);
            wrr(ADR_FLAGS, 16'h001f);
            t0 = n_trig;
            wrr(5'(3 * c), 16'h8000);
            wait_flag(c, 40);
            wrr(5'(3 * c), 16'h0000);
            nop(3);
            chk16(16'(n_trig - t0), c == 4 ? 16'h0001 : 16'h0000);
        end
        wrr(5'h09, 16'h0008); // coherent 32-bit read while stopped
        d = 16'($urandom);
        wrr(5'h0a, d);
        wrr(5'h0d, ~d);
        rdr(5'h0a, e);
        chk16(e, d);
        rdr(ADR_HOLD1, e);
        chk16(e, ~d);
        report_and_stop();
    end
endmodule
